// *** pkg/rfc_pkg.sv ***
`default_nettype none
package rfc_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int          FIFO_DEPTH = 24;
    localparam int          BYTE_W     = 8;
    localparam int          CNT_W      = 5;
    localparam int          LEN_W      = 12;
    localparam int          RXL_W      = 10;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0]  ADR_RXLEN  = 8'h1b;
    localparam logic [7:0]  ADR_FSTAT  = 8'h1c;
    localparam logic [7:0]  ADR_TXLEN1 = 8'h1d;
    localparam logic [7:0]  ADR_TXLEN2 = 8'h1e;
    localparam logic [7:0]  ADR_FIFO   = 8'h1f;
    // ----------------------------------------
    // Direct command codes
    // ----------------------------------------
    localparam logic [7:0]  CMD_IDLE   = 8'h80;
    localparam logic [7:0]  CMD_INIT   = 8'h83;
    localparam logic [7:0]  CMD_HOPM   = 8'h84;
    localparam logic [7:0]  CMD_HOPA   = 8'h85;
    localparam logic [7:0]  CMD_ADC    = 8'h87;
    localparam logic [7:0]  CMD_FRST   = 8'h8f;
    localparam logic [7:0]  CMD_TXC    = 8'h90;
    localparam logic [7:0]  CMD_TXH    = 8'h91;
    localparam logic [7:0]  CMD_TXN    = 8'h92;
    localparam logic [7:0]  CMD_DTXN   = 8'h93;
    localparam logic [7:0]  CMD_DTXC   = 8'h94;
    localparam logic [7:0]  CMD_RXBLK  = 8'h96;
    localparam logic [7:0]  CMD_RXEN   = 8'h97;
    localparam logic [7:0]  CMD_QUERY  = 8'h98;
    localparam logic [7:0]  CMD_QADJD  = 8'h9c;
    localparam logic [7:0]  CMD_REQRN  = 8'h9f;
    // ----------------------------------------
    // Levels, lengths and timing
    // ----------------------------------------
    localparam logic [4:0]  HI_LEVEL   = 5'h12;
    localparam logic [4:0]  LO_LEVEL   = 5'h06;
    localparam logic [4:0]  RDY_LIMIT  = 5'h16;
    localparam logic [11:0] START_CNT  = 12'h003;
    localparam logic [11:0] QUERY_TX   = 12'h002;
    localparam logic [9:0]  QUERY_RXL  = 10'h010;
    localparam logic [9:0]  REQRN_RXL  = 10'h020;
    localparam int          FOVE_BIT   = 5;
    localparam int          CLK_NS     = 4;
    localparam int          ADC_NS     = 20000;
    localparam int          ADC_CYC    = ADC_NS / CLK_NS;

    typedef enum logic [1:0] {
        CRC_16,
        CRC_NONE,
        CRC_5
    } rfc_crc_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       cmd;
        logic [7:0] addr;
        logic [7:0] data;
    } rfc_host_req_t;

    typedef struct packed {
        logic       start;
        rfc_crc_t   crc;
        logic       hdr;
        logic [7:0] code;
    } rfc_tx_ctl_t;
endpackage
`default_nettype wire

// *** hdl/rfc_ctrl.sv ***
// Functional notes
// - Nonzero receive bit count stops receiver after that many bits; zero stops on pause.
// - Query commands force receive length 16; random-number request forces 32.
// - Receive bit count clears at reset, enable low and after good reception.
// - High-level flag rises when receiving and 18 bytes are held.
// - Low-level flag rises when transmitting and six bytes or fewer remain.
// - Overflow flag, status bit 5, sets when writing into a full FIFO.
// - Status low five bits give the unread byte count.
// - Twelve-bit byte count: bits 11..4 in first register, 3..0 upper nibble of second.
// - First transmit length register clears at reset, enable low and frame end.
// - Three-bit partial byte size is used only when the partial flag is one.
// - Second transmit length register cannot be read back by the host.
// - Low bits of second register report valid bits of last received byte.
// - Data port reaches a 24-byte ring with wrapping pointers.
// - Command codes 80..9f decoded; undefined codes ignored.
// - Software init clears all logic except the enable filter, like a power-on reset.
// - Command 84 selects main divider (default), 85 auxiliary divider.
// - Command 87 starts a conversion of the selected source into the readout.
// - FIFO reset clears pointers, interrupt flags and the error position.
// - Transmit starts at third byte written, or when a shorter message is complete.
// - Transmit commands append CRC-16, except the no-CRC variants 92 and 93; 91 flags header bit.
// - Query sends CRC-5; repeat and adjust queries send no CRC.
// - Receiver block holds decoder in reset until enable command, or end of transmit once any receive wait has run out.
// - Conversion result valid within twenty microseconds of the trigger.
`timescale 1ns/1ps
`default_nettype none

module rfc_fifo #(
    parameter int W = 8,
    parameter int D = 24,
    parameter int CW = 5
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          clear,
    // Fill side
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    // Drain side
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [CW-1:0]      count
);
    typedef struct packed {
        logic [CW-1:0] wp;
        logic [CW-1:0] rp;
        logic [CW-1:0] cnt;
    } rfc_fifo_st_t;

    localparam logic [CW-1:0] LAST = CW'(D - 1);
    localparam logic [CW-1:0] FULL = CW'(D);

    rfc_fifo_st_t  r;
    rfc_fifo_st_t  next_r;
    logic [W-1:0]  mem [D];
    logic          push;
    logic          pop;

    assign in_ready  = (r.cnt != FULL);
    assign out_valid = (r.cnt != '0);
    assign out_data  = mem[r.rp];
    assign count     = r.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_r = r;
        // Pointers wrap at the last cell, not at a power of two
        if (push) begin
            next_r.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
        end
        if (pop) begin
            next_r.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
        end
        next_r.cnt = r.cnt + CW'(push) - CW'(pop);
        if (clear) begin
            next_r = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
        if (push && !clear) begin
            mem[r.wp] <= in_data;
        end
    end

    no_full_push_a: assert property (@(posedge clk) disable iff (reset)
        (in_valid && !in_ready && !out_ready && !clear) |=> (r.cnt == FULL && $stable(r.wp)))
        else $error("write into full FIFO changed it");
endmodule

module rfc_ctrl
    import rfc_pkg::*;
#(
    parameter int ADC_WAIT = ADC_CYC
) (
    // Clock, reset and enable pin
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 en,
    // Host register and command port
    input  wire rfc_host_req_t        host,
    output logic [7:0]                host_rdata,
    // Transmitter
    output rfc_tx_ctl_t               tx_ctl,
    output logic                      tx_byte_valid,
    input  wire logic                 tx_byte_ready,
    output logic [7:0]                tx_byte,
    output logic [11:0]               tx_complete_bytes,
    output logic [3:0]                tx_partial,
    input  wire logic                 tx_eof,
    // Receiver
    input  wire logic                 rx_byte_valid,
    output logic                      rx_byte_ready,
    input  wire logic [7:0]           rx_byte,
    input  wire logic                 rx_done,
    input  wire logic [4:0]           rx_tail,
    input  wire logic                 rx_wait_active,
    output logic [9:0]                rx_bit_limit,
    output logic                      rx_stop_on_pause,
    output logic                      rx_block,
    // Synthesizer, converter and flags
    output logic                      pll_aux_sel,
    output logic                      adc_start,
    input  wire logic [7:0]           adc_value,
    output logic [7:0]                adc_result,
    output logic                      flags_clear
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic          en_s1;
        logic          en_s2;
        logic          en_s3;
        logic          en_ok;
        logic [7:0]    rxlen;
        logic          q_len;
        logic          r_len;
        logic [9:0]    rx_limit;
        logic          pause_stop;
        logic [7:0]    txh;
        logic [7:0]    txl;
        logic [4:0]    tail;
        logic          fove;
        logic [7:0]    rdata;
        logic          tx_mode;
        logic          tx_armed;
        logic [11:0]   wr_cnt;
        rfc_tx_ctl_t   tx;
        logic          blk;
        logic          rel_pend;
        logic          aux;
        logic          adc_go;
        logic          adc_busy;
        logic [12:0]   adc_cnt;
        logic [7:0]    adc_res;
        logic          clr;
        logic          rx_rdy;
        logic          out_v;
        logic [7:0]    out_d;
    } rfc_st_t;

    rfc_st_t       r;
    rfc_st_t       next_r;

    logic          wr_fifo;
    logic          rd_fifo;
    logic          f_in_valid;
    logic          f_in_ready;
    logic [7:0]    f_in_data;
    logic          f_out_valid;
    logic          f_out_ready;
    logic [7:0]    f_out_data;
    logic [4:0]    f_cnt;
    logic          f_clear;
    logic          tx_pop;
    logic          wipe;
    logic          fhil;
    logic          flol;
    logic [7:0]    fstat;
    logic [11:0]   tot;

    // ----------------------------------------
    // Data path glue
    // ----------------------------------------
    assign wr_fifo     = host.wr && host.addr == ADR_FIFO;
    assign rd_fifo     = host.rd && host.addr == ADR_FIFO;
    // Host writes win the fill port; the receiver sees ready drop first
    assign f_in_valid  = wr_fifo || rx_byte_valid;
    assign f_in_data   = wr_fifo ? host.data : rx_byte;
    assign tx_pop      = r.tx_mode && !rd_fifo && f_out_valid && (!r.out_v || tx_byte_ready);
    assign f_out_ready = rd_fifo || tx_pop;
    assign wipe        = host.cmd && host.data == CMD_INIT || !r.en_ok;
    assign f_clear     = wipe || host.cmd && host.data == CMD_FRST;
    assign fhil        = !r.tx_mode && f_cnt >= HI_LEVEL;
    assign flol        = r.tx_mode && f_cnt <= LO_LEVEL;
    assign fstat       = {fhil, flol, r.fove, f_cnt};
    // Partial byte counts only when its flag is set
    assign tot         = r.q_len ? QUERY_TX : {r.txh, r.txl[7:4]} + LEN_W'(r.txl[0]);

    rfc_fifo #(
        .W  (BYTE_W),
        .D  (FIFO_DEPTH),
        .CW (CNT_W)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .clear     (f_clear),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data),
        .count     (f_cnt)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_r = r;
        next_r.en_s1 = en;
        next_r.en_s2 = r.en_s1;
        next_r.en_s3 = r.en_s2;
        if (r.en_s2 == r.en_s3) begin
            next_r.en_ok = r.en_s3;
        end
        next_r.tx.start = 1'b0;
        next_r.adc_go = 1'b0;
        next_r.clr = 1'b0;
        next_r.rx_rdy = f_cnt < RDY_LIMIT;

        // Register writes
        if (host.wr) begin
            unique case (host.addr)
                ADR_RXLEN:  next_r.rxlen = host.data;
                ADR_TXLEN1: next_r.txh = host.data;
                ADR_TXLEN2: next_r.txl = host.data;
                default: ;
            endcase
        end
        if (wr_fifo && !f_in_ready) begin
            next_r.fove = 1'b1;
        end

        // Register reads; the transmit half of 1e never reads back
        if (host.rd) begin
            unique case (host.addr)
                ADR_RXLEN:  next_r.rdata = r.rxlen;
                ADR_FSTAT:  next_r.rdata = fstat;
                ADR_TXLEN1: next_r.rdata = r.txh;
                ADR_TXLEN2: next_r.rdata = {3'h0, r.tail};
                ADR_FIFO:   next_r.rdata = f_out_valid ? f_out_data : 8'h00;
                default:    next_r.rdata = 8'h00;
            endcase
        end

        // Transmit start once enough bytes are in
        if (r.tx_armed && wr_fifo && f_in_ready) begin
            next_r.wr_cnt = r.wr_cnt + 1'b1;
            if (next_r.wr_cnt >= START_CNT || next_r.wr_cnt >= tot) begin
                next_r.tx_armed = 1'b0;
                next_r.tx.start = 1'b1;
            end
        end

        // Byte register toward the transmitter
        if (r.out_v && tx_byte_ready) begin
            next_r.out_v = 1'b0;
        end
        if (tx_pop) begin
            next_r.out_v = 1'b1;
            next_r.out_d = f_out_data;
        end

        // Direct commands
        if (host.cmd) begin
            case (host.data)
                CMD_IDLE: ;
                CMD_HOPM: next_r.aux = 1'b0;
                CMD_HOPA: next_r.aux = 1'b1;
                CMD_ADC: begin
                    next_r.adc_go = 1'b1;
                    next_r.adc_busy = 1'b1;
                    next_r.adc_cnt = '0;
                end
                CMD_FRST: begin
                    next_r.fove = 1'b0;
                    next_r.clr = 1'b1;
                    next_r.out_v = 1'b0;
                end
                CMD_TXC, CMD_TXH, CMD_TXN, CMD_DTXN, CMD_DTXC, CMD_QUERY: begin
                    next_r.tx_mode = 1'b1;
                    next_r.tx_armed = 1'b1;
                    next_r.wr_cnt = '0;
                    next_r.tx.code = host.data;
                    next_r.tx.hdr = host.data == CMD_TXH;
                    next_r.tx.crc = (host.data == CMD_TXN || host.data == CMD_DTXN) ? CRC_NONE : CRC_16;
                    if (host.data == CMD_QUERY) begin
                        next_r.tx.crc = CRC_5;
                        next_r.q_len = 1'b1;
                    end
                end
                CMD_RXBLK: {next_r.blk, next_r.rel_pend} = 2'b10;
                CMD_RXEN: begin
                    next_r.blk = 1'b0;
                    next_r.rel_pend = 1'b0;
                end
                8'h99, 8'h9a, 8'h9b, CMD_QADJD, 8'h9d, 8'h9e, CMD_REQRN: begin
                    next_r.tx_mode = 1'b1;
                    next_r.tx.start = 1'b1;
                    next_r.tx.code = host.data;
                    next_r.tx.hdr = 1'b0;
                    next_r.tx.crc = CRC_NONE;
                    next_r.q_len = host.data <= CMD_QADJD;
                    next_r.r_len = host.data == CMD_REQRN;
                end
                default: ;
            endcase
        end

        // Frame end from the transmitter
        if (tx_eof) begin
            next_r.tx_mode = 1'b0;
            next_r.txh = 8'h00;
            next_r.rel_pend = next_r.blk;
        end
        // Pending release after frame end waits until any receive wait has run out
        if (next_r.rel_pend && !rx_wait_active && !tx_eof) begin
            next_r.blk = 1'b0;
            next_r.rel_pend = 1'b0;
        end

        // Good reception
        if (rx_done) begin
            next_r.rxlen = 8'h00;
            next_r.q_len = 1'b0;
            next_r.r_len = 1'b0;
            next_r.tail = rx_tail;
        end

        // Converter settling
        if (r.adc_busy) begin
            next_r.adc_cnt = r.adc_cnt + 1'b1;
            if (r.adc_cnt == 13'(ADC_WAIT - 1)) begin
                next_r.adc_busy = 1'b0;
                next_r.adc_res = adc_value;
            end
        end

        next_r.rx_limit = {2'h0, next_r.rxlen};
        if (next_r.r_len) begin
            next_r.rx_limit = REQRN_RXL;
        end else if (next_r.q_len) begin
            next_r.rx_limit = QUERY_RXL;
        end
        next_r.pause_stop = next_r.rx_limit == '0;

        // Soft init and enable low act like power-on reset
        if (wipe) begin
            next_r = '0;
            next_r.en_s1 = en;
            next_r.en_s2 = r.en_s1;
            next_r.en_s3 = r.en_s2;
            next_r.en_ok = r.en_ok;
            if (r.en_s2 == r.en_s3) begin
                next_r.en_ok = r.en_s3;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign host_rdata        = r.rdata;
    assign tx_ctl            = r.tx;
    assign tx_byte_valid     = r.out_v;
    assign tx_byte           = r.out_d;
    assign tx_complete_bytes = {r.txh, r.txl[7:4]};
    assign tx_partial        = r.txl[3:0];
    assign rx_byte_ready     = r.rx_rdy;
    assign rx_bit_limit      = r.rx_limit;
    assign rx_stop_on_pause  = r.pause_stop;
    assign rx_block          = r.blk;
    assign pll_aux_sel       = r.aux;
    assign adc_start         = r.adc_go;
    assign adc_result        = r.adc_res;
    assign flags_clear       = r.clr;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    rxlen_clear_a: assert property (@(posedge clk) disable iff (reset)
        rx_done && !host.wr |=> r.rxlen == 8'h00)
        else $error("receive length not cleared after reception");

    query_len_a: assert property (@(posedge clk) disable iff (reset)
        host.cmd && host.data == CMD_QUERY && r.en_ok && !rx_done |=> ##1 rx_bit_limit == QUERY_RXL)
        else $error("query receive length not 16");

    reqrn_len_a: assert property (@(posedge clk) disable iff (reset)
        host.cmd && host.data == CMD_REQRN && r.en_ok && !rx_done |=> ##1 rx_bit_limit == REQRN_RXL)
        else $error("request receive length not 32");

    overflow_flag_a: assert property (@(posedge clk) disable iff (reset)
        wr_fifo && !f_in_ready && !wipe && !host.cmd |=> r.fove ##1 fstat[FOVE_BIT] || host.cmd)
        else $error("overflow flag missing");

    txlen_eof_a: assert property (@(posedge clk) disable iff (reset)
        tx_eof |=> r.txh == 8'h00)
        else $error("first length register not cleared at frame end");

    fifo_reset_a: assert property (@(posedge clk) disable iff (reset)
        host.cmd && host.data == CMD_FRST |=> f_cnt == '0 && !r.fove && flags_clear)
        else $error("FIFO reset incomplete");

    tx_start_a: assert property (@(posedge clk) disable iff (reset)
        r.tx_armed && wr_fifo && f_in_ready && !wipe && !host.cmd && r.wr_cnt == 12'h002 |=> tx_ctl.start)
        else $error("transmit did not start at third byte");

    adc_bound_a: assert property (@(posedge clk) disable iff (reset)
        r.adc_busy |-> r.adc_cnt < 13'(ADC_WAIT))
        else $error("conversion longer than allowed");

    hi_level_a: assert property (@(posedge clk) disable iff (reset)
        $rose(fstat[7]) |-> !r.tx_mode && f_cnt >= HI_LEVEL && $past(f_cnt) < HI_LEVEL || $fell(r.tx_mode))
        else $error("high level flag at wrong level");

    block_rx_a: assert property (@(posedge clk) disable iff (reset)
        host.cmd && host.data == CMD_RXBLK && !wipe && !tx_eof |=> rx_block)
        else $error("receiver not held in reset");
endmodule
`default_nettype wire

// *** verification/rfc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfc_host_model
    import rfc_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Register and command port
    output var rfc_host_req_t host,
    input  wire logic [7:0] rdata
);
    initial host = '0;
    // One request a call, always two full cycles apart; writes go out in the order the caller makes them
    task automatic acc(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        host = '{wr: k[2], rd: k[1], cmd: k[0], addr: a, data: d};
        @(negedge clk);
        host = '0;
        @(negedge clk);
        q = rdata;
    endtask
endmodule
`default_nettype wire

// *** verification/rfc_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfc_ctrl_test
    import rfc_pkg::*;
;
    localparam int ADC_W = 20;
    logic          clk, reset, en, tx_byte_ready, tx_eof, rx_done, rx_wait_active, rx_byte_valid;
    logic          tx_byte_valid, rx_byte_ready, rx_stop_on_pause, rx_block, pll_aux_sel, adc_start, flags_clear;
    logic [7:0]    host_rdata, tx_byte, adc_value, adc_result, q, d, rx_byte;
    logic [11:0]   tx_complete_bytes;
    logic [3:0]    tx_partial;
    logic [4:0]    rx_tail;
    logic [9:0]    rx_bit_limit;
    rfc_host_req_t host;
    rfc_tx_ctl_t   tx_ctl, last_tx;
    logic [7:0]    exp_q[$], txq[$];
    logic [7:0]    codes[5] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h94};
    int            err_total, n_compared, n_start, n_adc, n_clr, cyc, seed, i, j;

    rfc_host_model u_host (.clk(clk), .host(host), .rdata(host_rdata));
    rfc_ctrl #(.ADC_WAIT(ADC_W)) u_dut (
        .clk(clk), .reset(reset), .en(en), .host(host), .host_rdata(host_rdata),
        .tx_ctl(tx_ctl), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready), .tx_byte(tx_byte),
        .tx_complete_bytes(tx_complete_bytes), .tx_partial(tx_partial), .tx_eof(tx_eof),
        .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready), .rx_byte(rx_byte), .rx_done(rx_done),
        .rx_tail(rx_tail), .rx_wait_active(rx_wait_active), .rx_bit_limit(rx_bit_limit),
        .rx_stop_on_pause(rx_stop_on_pause), .rx_block(rx_block), .pll_aux_sel(pll_aux_sel),
        .adc_start(adc_start), .adc_value(adc_value), .adc_result(adc_result), .flags_clear(flags_clear));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // Monitors, stalling sink, timeout
    // ----------------------------------------
    always @(negedge clk) tx_byte_ready <= 1'($random(seed));
    always @(posedge clk) begin
        cyc++;
        if (tx_ctl.start === 1'b1) begin
            last_tx <= tx_ctl;
            n_start++;
        end
        if (adc_start === 1'b1) n_adc++;
        if (flags_clear === 1'b1) n_clr++;
        if (tx_byte_valid === 1'b1 && tx_byte_ready === 1'b1) txq.push_back(tx_byte);
        if (cyc == 30000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    function automatic logic [7:0] exp_stat(input logic tx, ov, input int n);
        return {!tx && n >= 18, tx && n <= 6, ov, 5'(n)};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_host.acc(3'b100, a, v, q);
    endtask
    task automatic rd(input logic [7:0] a);
        u_host.acc(3'b010, a, 8'h00, q);
    endtask
    task automatic cmd(input logic [7:0] c);
        u_host.acc(3'b001, 8'h00, c, q);
    endtask
    // s high: transmit frame end, s low: good reception with a fresh tail
    task automatic ev(input logic s);
        @(negedge clk);
        rx_tail = 5'($random(seed));
        tx_eof = s;
        rx_done = !s;
        @(negedge clk);
        tx_eof = 1'b0;
        rx_done = 1'b0;
        @(negedge clk);
    endtask

    initial begin
        seed = 32'hd0e7;
        {reset, en, tx_eof, rx_done, rx_wait_active, rx_byte_valid, rx_tail, adc_value} = {2'b11, 17'h0};
        repeat (12) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        repeat (6) @(negedge clk);
        for (j = 27; j <= 30; j++) begin
            rd(8'(j));
            chk(q, 8'h00);
        end
        rd(8'h05);
        chk(q, 8'h00);
        // ----------------------------------------
        // Ring fill, overflow, drain, clear
        // ----------------------------------------
        for (i = 0; i < FIFO_DEPTH; i++) begin
            d = 8'($random(seed));
            exp_q.push_back(d);
            wr(ADR_FIFO, d);
        end
        rd(ADR_FSTAT);
        chk(q, 8'h98);
        chk(rx_byte_ready, 16'h0);
        wr(ADR_FIFO, 8'h77);
        rd(ADR_FSTAT);
        chk(q, 8'hb8);
        for (i = 0; i < FIFO_DEPTH; i++) begin
            rd(ADR_FIFO);
            chk(q, exp_q[i]);
        end
        rd(ADR_FSTAT);
        chk(q, 8'h20);
        cmd(CMD_FRST);
        rd(ADR_FSTAT);
        chk(q, 8'h00);
        chk(16'(n_clr), 16'h1);
        @(negedge clk) {rx_byte_valid, rx_byte} = {1'b1, d};
        @(negedge clk) rx_byte_valid = 1'b0;
        rd(ADR_FIFO);
        chk(q, d);
        // ----------------------------------------
        // Transmit variants, three-byte frames
        // ----------------------------------------
        for (j = 0; j < 5; j++) begin
            cmd(codes[j]);
            wr(ADR_TXLEN1, 8'h00);
            wr(ADR_TXLEN2, 8'h30);
            rd(ADR_TXLEN2);
            chk(q, 8'h00);
            rd(ADR_FSTAT);
            chk(q, exp_stat(1'b1, 1'b0, 0));
            i = n_start;
            txq.delete();
            exp_q.delete();
            for (int k = 0; k < 3; k++) begin
                d = 8'($random(seed));
                exp_q.push_back(d);
                chk(16'(n_start - i), 16'h0);
                wr(ADR_FIFO, d);
            end
            chk(16'(n_start - i), 16'h1);
            chk(last_tx.code, codes[j]);
            chk(16'(last_tx.crc), 16'(j == 2 || j == 3 ? CRC_NONE : CRC_16));
            chk(last_tx.hdr, 16'(j == 1));
            for (int w = 0; w < 80 && txq.size() < 3; w++) @(negedge clk);
            for (int k = 0; k < 3; k++) chk(txq[k], exp_q[k]);
            ev(1'b1);
        end
        // ----------------------------------------
        // Query family and random-number request
        // ----------------------------------------
        for (j = 'h98; j <= 'h9e; j++) begin
            i = n_start;
            cmd(8'(j));
            chk(rx_bit_limit, j <= 'h9c ? 10'h010 : 10'h000);
            if (j == 'h98) begin
                wr(ADR_FIFO, 8'h0f);
                wr(ADR_FIFO, 8'h25);
            end
            chk(16'(n_start - i), 16'h1);
            chk(16'(last_tx.crc), 16'(j == 'h98 ? CRC_5 : CRC_NONE));
            ev(1'b0);
            chk(rx_bit_limit, 10'h000);
            rd(ADR_TXLEN2);
            chk(q, {3'h0, rx_tail});
            ev(1'b1);
        end
        cmd(CMD_REQRN);
        chk(rx_bit_limit, 10'h020);
        ev(1'b0);
        ev(1'b1);
        d = 8'($random(seed)) | 8'h01;
        wr(ADR_RXLEN, d);
        chk({rx_stop_on_pause, rx_bit_limit}, {3'b000, d});
        ev(1'b0);
        chk(rx_stop_on_pause, 16'h1);
        rd(ADR_RXLEN);
        chk(q, 8'h00);
        // ----------------------------------------
        // Length fields, frame end, synthesizer, converter, receiver block
        // ----------------------------------------
        wr(ADR_TXLEN1, 8'ha5);
        wr(ADR_TXLEN2, 8'h7b);
        chk({tx_complete_bytes, tx_partial}, 16'ha57b);
        rd(ADR_TXLEN1);
        chk(q, 8'ha5);
        ev(1'b1);
        rd(ADR_TXLEN1);
        chk(q, 8'h00);
        cmd(CMD_HOPA);
        chk(pll_aux_sel, 16'h1);
        cmd(CMD_HOPM);
        chk(pll_aux_sel, 16'h0);
        adc_value = 8'($random(seed));
        i = n_adc;
        cmd(CMD_ADC);
        chk(16'(n_adc - i), 16'h1);
        repeat (ADC_W + 2) @(negedge clk);
        chk(adc_result, adc_value);
        cmd(CMD_RXBLK);
        chk(rx_block, 16'h1);
        cmd(CMD_RXEN);
        chk(rx_block, 16'h0);
        cmd(CMD_RXBLK);
        rx_wait_active = 1'b1;
        ev(1'b1);
        chk(rx_block, 16'h1);
        rx_wait_active = 1'b0;
        cmd(CMD_IDLE);
        chk(rx_block, 16'h0);
        // Soft init and enable low both wipe state; the enable filter needs time to recover
        cmd(CMD_HOPA);
        wr(ADR_TXLEN1, 8'h3c);
        cmd(CMD_INIT);
        repeat (6) @(negedge clk);
        chk(pll_aux_sel, 16'h0);
        rd(ADR_TXLEN1);
        chk(q, 8'h00);
        wr(ADR_TXLEN1, 8'h3c);
        en = 1'b0;
        repeat (4) @(negedge clk);
        en = 1'b1;
        repeat (8) @(negedge clk);
        rd(ADR_TXLEN1);
        chk(q, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
